// *** rtl/gtc_pkg.sv ***
// Purpose: shared constants and carriers of the gated 16-bit timer core
// Assumes: 8-bit register port, one 100 MHz system clock
// Notes:   register offsets are word indices on the plain register port
package gtc_pkg;

	// register port geometry
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;

	// register offsets
	localparam logic [2:0] OFS_COUNT_LOW  = 3'h0;
	localparam logic [2:0] OFS_COUNT_HIGH = 3'h1;
	localparam logic [2:0] OFS_CTRL       = 3'h2;
	localparam logic [2:0] OFS_GATE_CTRL  = 3'h3;
	localparam logic [2:0] OFS_IRQ_STATUS = 3'h4;
	localparam logic [2:0] OFS_IRQ_MASK   = 3'h5;

	// field positions
	localparam int unsigned GATE_EN_POS  = 7;
	localparam int unsigned OVF_FLAG_POS = 0;

	// clock select codes
	localparam logic [1:0] CS_INSTR = 2'h0;
	localparam logic [1:0] CS_FOSC  = 2'h1;
	localparam logic [1:0] CS_EXT   = 2'h2;
	localparam logic [1:0] CS_LFOSC = 2'h3;

	// values after reset and the count limit
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [7:0]  MASK_RST  = 8'h00;
	localparam logic [15:0] COUNT_MAX = 16'hffff;

	// timing
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned INSTR_DIV   = 4;
	localparam logic [1:0]  INSTR_LAST  = 2'(INSTR_DIV - 1);
	localparam int unsigned PRE_W       = 3;

	// register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} gtc_bus_t;

	// control register layout
	typedef struct packed {
		logic [1:0] clk_sel;
		logic [1:0] prescale;
		logic       osc_en;
		logic       async_sel;
		logic       rsvd;
		logic       run;
	} gtc_ctrl_t;

	// pin levels after synchronisation
	typedef struct packed {
		logic xtal;
		logic lfosc;
		logic ext;
	} gtc_pins_t;

endpackage : gtc_pkg

// *** rtl/gtc_sync3.sv ***
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs are asynchronous to ref_clk_i
// Notes:   a new level is taken once stages two and three agree
`timescale 1ns/100ps
module gtc_sync3
#(
	parameter int unsigned WIDTH = 3
)
(
	// clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	// asynchronous inputs
	input  wire logic [WIDTH-1:0] async_i,
	// filtered levels
	output logic      [WIDTH-1:0] level_o
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// shift chain, stage1 feeds only stage2
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			stage1  <= '0;
			stage2  <= '0;
			stage3  <= '0;
			level_o <= '0;
		end
		else
		begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
			for (int i = 0; i < WIDTH; i++)
			begin
				if (stage2[i] == stage3[i])
				begin
					level_o[i] <= stage3[i];
				end
			end
		end
	end

endmodule : gtc_sync3

// *** rtl/gtc_timer.sv ***
// Purpose: 16-bit gated timer/counter core with byte register access
// Assumes: ref_clk_i is the system clock; gate logic lives outside
// Notes:   read data stand one cycle after the read strobe
`timescale 1ns/100ps
module gtc_timer
(
	// clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	// register port
	input  wire gtc_pkg::gtc_bus_t bus_i,
	output logic [7:0]             rdata_o,
	// pins and neighbours
	input  wire logic              ext_count_i,
	input  wire logic              lfosc_i,
	input  wire logic              xtal_in_i,
	input  wire logic              gate_open_i,
	input  wire logic              sleep_i,
	// outputs
	output logic                   xtal_drive_o,
	output logic                   irq_o,
	output logic                   wake_o,
	output logic [15:0]            count_o
);

	// whole state of the core
	typedef struct packed {
		logic [15:0]        count;
		logic [2:0]         pre;
		logic [1:0]         div4;
		gtc_pkg::gtc_ctrl_t ctrl;
		logic               gate_en;
		logic               armed;
		logic               pend;
		gtc_pkg::gtc_pins_t prev;
		logic               status;
		logic               mask;
		logic [7:0]         rdata;
		logic               irq;
		logic               wake;
		logic               xdrv;
	} gtc_state_t;

	gtc_state_t         s;
	gtc_state_t         next_s;
	gtc_pkg::gtc_pins_t pins;

	// largest prescale count for a field value
	function automatic logic [2:0] gtc_pre_max(input logic [1:0] ps);
		logic [2:0] m;
		m = 3'h0;
		case (ps)
			2'h0: m = 3'h0;
			2'h1: m = 3'h1;
			2'h2: m = 3'h3;
			default: m = 3'h7;
		endcase
		return m;
	endfunction : gtc_pre_max

	// rising edge between two samples
	function automatic logic gtc_rise(input logic now, input logic was);
		return now & ~was;
	endfunction : gtc_rise

	// pin synchronisers
	gtc_sync3
	#(
		.WIDTH   (3)
	)
	u_sync
	(
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.async_i   ({xtal_in_i, lfosc_i, ext_count_i}),
		.level_o   (pins)
	);

	// decoded accesses
	logic wr_low;
	logic wr_high;
	logic wr_ctrl;
	logic wr_gate;
	logic wr_stat;
	logic wr_mask;
	logic wr_count;

	// address decode of writes
	always_comb
	begin
		wr_low  = 1'b0;
		wr_high = 1'b0;
		wr_ctrl = 1'b0;
		wr_gate = 1'b0;
		wr_stat = 1'b0;
		wr_mask = 1'b0;
		if (bus_i.wr)
		begin
			if (bus_i.addr == gtc_pkg::OFS_COUNT_LOW)
				wr_low = 1'b1;
			else if (bus_i.addr == gtc_pkg::OFS_COUNT_HIGH)
				wr_high = 1'b1;
			else if (bus_i.addr == gtc_pkg::OFS_CTRL)
				wr_ctrl = 1'b1;
			else if (bus_i.addr == gtc_pkg::OFS_GATE_CTRL)
				wr_gate = 1'b1;
			else if (bus_i.addr == gtc_pkg::OFS_IRQ_STATUS)
				wr_stat = 1'b1;
			else if (bus_i.addr == gtc_pkg::OFS_IRQ_MASK)
				wr_mask = 1'b1;
		end
		wr_count = wr_low | wr_high;
	end

	// edge and source terms
	logic ext_rise;
	logic ext_fall;
	logic lf_rise;
	logic xt_rise;
	logic instr_en;
	logic ext_edge;
	logic ext_tick;
	logic src_tick;
	logic pre_done;
	logic gate_ok;
	logic inc;
	logic ovf;
	logic async_ext;

	// source selection and qualification
	always_comb
	begin
		ext_rise  = gtc_rise(pins.ext, s.prev.ext);
		ext_fall  = gtc_rise(s.prev.ext, pins.ext);
		lf_rise   = gtc_rise(pins.lfosc, s.prev.lfosc);
		xt_rise   = gtc_rise(pins.xtal, s.prev.xtal);
		instr_en  = (s.div4 == gtc_pkg::INSTR_LAST);
		// crystal timer or armed pin counter
		if (s.ctrl.osc_en)
			ext_edge = xt_rise;
		else
			ext_edge = ext_rise & s.armed;
		async_ext = (s.ctrl.clk_sel == gtc_pkg::CS_EXT) & s.ctrl.async_sel;
		// async counts at once, sync waits for the instruction slot
		if (s.ctrl.async_sel)
			ext_tick = ext_edge;
		else
			ext_tick = s.pend & instr_en & ~sleep_i;
		case (s.ctrl.clk_sel)
			gtc_pkg::CS_INSTR: src_tick = instr_en & ~sleep_i;
			gtc_pkg::CS_FOSC:  src_tick = ~sleep_i;
			gtc_pkg::CS_LFOSC: src_tick = lf_rise & ~sleep_i;
			default:           src_tick = ext_tick;
		endcase
		pre_done = s.ctrl.run & src_tick &
			(s.pre >= gtc_pre_max(s.ctrl.prescale));
		gate_ok  = ~s.gate_en | gate_open_i;
		inc      = pre_done & gate_ok;
		ovf      = inc & (s.count == gtc_pkg::COUNT_MAX);
	end

	// next state
	always_comb
	begin
		next_s       = s;
		next_s.rdata = 8'h00;
		next_s.div4  = 2'(s.div4 + 2'h1);
		next_s.prev  = pins;

		// prescaler, hidden and cleared by count writes
		if (wr_count)
			next_s.pre = 3'h0;
		else if (pre_done)
			next_s.pre = 3'h0;
		else if (s.ctrl.run & src_tick)
			next_s.pre = 3'(s.pre + 3'h1);

		// counter: byte load wins over increment
		if (wr_low)
			next_s.count[7:0] = bus_i.wdata;
		else if (wr_high)
			next_s.count[15:8] = bus_i.wdata;
		else if (inc)
			next_s.count = 16'(s.count + 16'h0001);

		// falling edge arms the pin counter
		if (~s.ctrl.run | wr_count)
			next_s.armed = 1'b0;
		else if (ext_fall)
			next_s.armed = 1'b1;

		// pending edge for synchronised external mode
		if (~s.ctrl.run | wr_count | s.ctrl.async_sel)
			next_s.pend = 1'b0;
		else if (ext_edge)
			next_s.pend = 1'b1;
		else if (instr_en)
			next_s.pend = 1'b0;

		// control registers
		if (wr_ctrl)
			next_s.ctrl = gtc_pkg::gtc_ctrl_t'(bus_i.wdata);
		if (wr_gate)
			next_s.gate_en = bus_i.wdata[gtc_pkg::GATE_EN_POS];
		if (wr_mask)
			next_s.mask = bus_i.wdata[gtc_pkg::OVF_FLAG_POS];

		// sticky flag, set wins over write-one clear
		if (wr_stat & bus_i.wdata[gtc_pkg::OVF_FLAG_POS])
			next_s.status = 1'b0;
		if (ovf)
			next_s.status = 1'b1;

		// interrupt and wake levels
		next_s.irq  = next_s.status & next_s.mask;
		next_s.wake = sleep_i & (s.wake | (ovf & async_ext));

		// crystal amplifier, independent of sleep
		next_s.xdrv = s.ctrl.osc_en & ~pins.xtal;

		// read decode
		if (bus_i.rd)
		begin
			if (bus_i.addr == gtc_pkg::OFS_COUNT_LOW)
				next_s.rdata = s.count[7:0];
			else if (bus_i.addr == gtc_pkg::OFS_COUNT_HIGH)
				next_s.rdata = s.count[15:8];
			else if (bus_i.addr == gtc_pkg::OFS_CTRL)
				next_s.rdata = s.ctrl;
			else if (bus_i.addr == gtc_pkg::OFS_GATE_CTRL)
				next_s.rdata = {s.gate_en, 7'h00};
			else if (bus_i.addr == gtc_pkg::OFS_IRQ_STATUS)
				next_s.rdata = {7'h00, s.status};
			else if (bus_i.addr == gtc_pkg::OFS_IRQ_MASK)
				next_s.rdata = {7'h00, s.mask};
			else
				next_s.rdata = 8'h00;
		end
	end

	// state register
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			s         <= '0;
			s.count   <= gtc_pkg::COUNT_RST;
			s.ctrl    <= gtc_pkg::gtc_ctrl_t'(gtc_pkg::CTRL_RST);
			s.mask    <= gtc_pkg::MASK_RST[0];
		end
		else
		begin
			s <= next_s;
		end
	end

	// outputs straight from state
	assign rdata_o      = s.rdata;
	assign irq_o        = s.irq;
	assign wake_o       = s.wake;
	assign xtal_drive_o = s.xdrv;
	assign count_o      = s.count;

endmodule : gtc_timer

// *** test/gtc_pin_src.sv ***
// Purpose: external clock or crystal seen at the count pin
// Assumes: period is a whole number of system clocks
// Notes:   idle low, first change after start is a rise
`timescale 1ns/100ps
module gtc_pin_src
#(
	parameter int unsigned HALF = 10
)
(
	// clock
	input  wire logic ref_clk_i,
	// oscillator on
	input  wire logic run_i,
	// pin level
	output logic      pin_o
);
	logic [7:0] cnt;

	// toggles every HALF clocks while running
	always_ff @(posedge ref_clk_i)
	begin
		if (!run_i)
		begin
			cnt   <= 8'h00;
			pin_o <= 1'b0;
		end
		else if (cnt == 8'(HALF - 1))
		begin
			cnt   <= 8'h00;
			pin_o <= ~pin_o;
		end
		else
			cnt <= cnt + 8'h01;
	end
endmodule : gtc_pin_src

// *** test/gtc_timer_sva.sv ***
// Purpose: port checks for the gated timer core
// Assumes: one clock, synchronous reset
// Notes:   bound to every gtc_timer
`timescale 1ns/100ps
module gtc_timer_sva
(
	// clock and reset
	input wire logic              ref_clk_i,
	input wire logic              rst_i,
	// watched ports
	input wire gtc_pkg::gtc_bus_t bus_i,
	input wire logic [7:0]        rdata_o,
	input wire logic [15:0]       count_o,
	input wire logic              irq_o,
	input wire logic              wake_o,
	input wire logic              sleep_i
);
	// all checks on the system clock
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	low_load_a: assert property (
		bus_i.wr && bus_i.addr == 3'h0 |=> count_o[7:0] == $past(bus_i.wdata))
		else $error("low byte not loaded");
	high_load_a: assert property (
		bus_i.wr && bus_i.addr == 3'h1 |=> count_o[15:8] == $past(bus_i.wdata))
		else $error("high byte not loaded");
	read_low_a: assert property (
		bus_i.rd && bus_i.addr == 3'h0 |=> rdata_o == $past(count_o[7:0]))
		else $error("low byte read wrong");
	read_idle_a: assert property (
		!bus_i.rd |=> rdata_o == 8'h00)
		else $error("read data outside read slot");
	read_gap_a: assert property (
		bus_i.rd && bus_i.addr > 3'h5 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	count_step_a: assert property (
		!bus_i.wr |=> 16'(count_o - $past(count_o)) <= 16'h0001)
		else $error("count jumped");
	wake_drop_a: assert property (
		!sleep_i |=> !wake_o)
		else $error("wake while awake");
	irq_cause_a: assert property (
		$rose(irq_o) |-> $past(count_o) == 16'hffff || $past(bus_i.wr))
		else $error("irq without cause");

	// main scenarios reached
	cover property (count_o == 16'hffff ##1 count_o == 16'h0000);
	cover property ($rose(irq_o));
	cover property ($rose(wake_o));
endmodule : gtc_timer_sva

bind gtc_timer gtc_timer_sva chk_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.bus_i(bus_i), .rdata_o(rdata_o), .count_o(count_o), .irq_o(irq_o),
	.wake_o(wake_o), .sleep_i(sleep_i));

// *** test/gtc_timer_tb.sv ***
// Purpose: register level test of the gated timer core
// Assumes: 100 MHz clock, pin source of 20 clock period
// Notes:   counts are checked as differences over fixed spans, the prescaler restart as absolute values
`timescale 1ns/100ps
module gtc_timer_tb;
	logic              ref_clk_i = 1'b0;
	logic              rst_i     = 1'b1;
	logic              gate      = 1'b0;
	logic              sleep     = 1'b0;
	logic              ext_run   = 1'b0;
	logic              lfosc     = 1'b0;
	gtc_pkg::gtc_bus_t bus       = '0;
	logic [7:0]        rdata;
	logic [15:0]       count;
	logic [15:0]       c0;
	logic              pin;
	logic              irq;
	logic              wake;
	logic              xdrv;
	int                mismatches = 0;
	int                checks     = 0;

	// clock and slow oscillator
	always #5 ref_clk_i = ~ref_clk_i;
	always
	begin
		repeat (8) @(posedge ref_clk_i);
		lfosc <= ~lfosc;
	end

	gtc_timer dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus),
		.rdata_o(rdata), .ext_count_i(pin), .lfosc_i(lfosc),
		.xtal_in_i(pin), .gate_open_i(gate), .sleep_i(sleep),
		.xtal_drive_o(xdrv), .irq_o(irq), .wake_o(wake), .count_o(count));
	gtc_pin_src src (.ref_clk_i(ref_clk_i), .run_i(ext_run), .pin_o(pin));

	task wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : tick

	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk_i) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk_i) bus <= '0;
	endtask : wr

	task rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge ref_clk_i) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk_i) bus <= '0;
		#1 chk("rdata", 16'(rdata), 16'(exp));
	endtask : rd

	// run with a control value, compare growth over 64 clocks
	task rate(input logic [7:0] c, input logic [15:0] exp);
		wr(3'h2, c);
		tick(20);
		c0 = count;
		tick(64);
		chk("rate", count - c0, exp);
	endtask : rate

	// count the pin source from a stopped, low pin
	task ext(input logic [7:0] c, input logic [15:0] v, input logic [15:0] n);
		@(posedge ref_clk_i) ext_run <= 1'b0;
		wr(3'h2, 8'h00);
		tick(8);
		wr(3'h0, v[7:0]);
		wr(3'h1, v[15:8]);
		wr(3'h2, c);
		@(posedge ref_clk_i) ext_run <= 1'b1;
		#1 c0 = count;
		tick(205);
		chk("ext", count - c0, n);
	endtask : ext

	// watchdog
	initial
	begin
		tick(20000);
		mismatches++;
		wrap_up();
	end

	// test sequence
	initial
	begin
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 6; a++) rd(3'(a), 8'h00);
		wr(3'h0, 8'h5a);
		wr(3'h1, 8'ha5);
		rd(3'h0, 8'h5a);
		rd(3'h1, 8'ha5);
		wr(3'h7, 8'hff);
		rd(3'h7, 8'h00);
		for (int p = 0; p < 4; p++)
		begin
			rate({2'h1, 2'(p), 4'h1}, 16'(64 >> p));
			rate({2'h0, 2'(p), 4'h1}, 16'(16 >> p));
		end
		// count write restarts the divide by eight from zero
		wr(3'h2, 8'h71);
		tick(5);
		wr(3'h0, 8'h00);
		tick(7);
		chk("pre_hold", 16'(count[7:0]), 16'h0000);
		tick(1);
		chk("pre_clear", 16'(count[7:0]), 16'h0001);
		rate(8'hc1, 16'h0004);
		rate(8'h40, 16'h0000);
		wr(3'h3, 8'h80);
		rate(8'h41, 16'h0000);
		@(posedge ref_clk_i) gate <= 1'b1;
		rate(8'h41, 16'h0040);
		@(posedge ref_clk_i) gate <= 1'b0;
		wr(3'h3, 8'h00);
		rate(8'h41, 16'h0040);
		@(posedge ref_clk_i) sleep <= 1'b1;
		rate(8'h41, 16'h0000);
		@(posedge ref_clk_i) sleep <= 1'b0;
		ext(8'h81, 16'h0000, 16'h0009);
		ext(8'h85, 16'h0000, 16'h0009);
		ext(8'h89, 16'h0000, 16'h000a);
		@(posedge ref_clk_i) sleep <= 1'b1;
		// crystal amplifier drives against a low input, asleep too
		@(posedge ref_clk_i) ext_run <= 1'b0;
		tick(8);
		chk("xdrv", 16'(xdrv), 16'h0001);
		wr(3'h2, 8'h00);
		tick(2);
		chk("xdrv", 16'(xdrv), 16'h0000);
		ext(8'h85, 16'hffff, 16'h0009);
		chk("wake", 16'(wake), 16'h0001);
		chk("irq", 16'(irq), 16'h0000);
		rd(3'h4, 8'h01);
		wr(3'h5, 8'h01);
		tick(2);
		chk("irq", 16'(irq), 16'h0001);
		wr(3'h4, 8'h01);
		tick(2);
		chk("irq", 16'(irq), 16'h0000);
		@(posedge ref_clk_i) sleep <= 1'b0;
		tick(2);
		chk("wake", 16'(wake), 16'h0000);
		wrap_up();
	end
endmodule : gtc_timer_tb
